// ===== regulator_volatile_location_map_test.sv
// Self-checking bench for the regulator volatile location map.
// Assumes rvlm_map and its defines header; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
`include "rvlm_defs.vh"
module regulator_volatile_location_map_test;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err, remote, hz60, cstb, e;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0, rdat;
  logic [6:0]  win;
  logic [15:0] v [16], cfgs [5], cfg = 16'h1F3D, sref = 16'h1234, aref, cmd, q;
  int          errors = 0, total_checks = 0, seed = 32'h513a, k;
  rvlm_map rvlm_map_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .volt_knob_i(v[0]), .stability_knob_knob_i(v[1]), .uspd_knob_i(v[2]), .exc_knob_i(v[3]), .reg_volt_i(v[4]),
    .freq_i(v[5]), .alarm_i(v[6]), .ext_lvl_i(v[7]), .setpt_i(v[8]), .adj_setpt_i(v[9]),
    .meas_volt_i(v[10]), .temp_i(v[11]), .kp_i(v[12]), .ki_i(v[13]), .overexc_i(v[14]),
    .underexc_i(v[15]), .cfg_param_i(cfg), .stored_ref_i(sref), .active_ref_o(aref),
    .use_remote_ref_o(remote), .freq_60hz_o(hz60), .volt_window_o(win), .command_o(cmd),
    .command_stb_o(cstb));
  function automatic logic [7:0] idx(int n);
    return (n < 7) ? 8'(8'h20 + n) : (n < 12) ? 8'(8'h22 + n) : 8'(8'h29 + n);
  endfunction
  // Model of a status read: alarm word passes whole, the rest saturate at their range.
  function automatic logic [15:0] model_rd(int n, logic [15:0] x);
    logic [15:0] lim;
    lim = (n == 4) ? `RVLM_VOLT_MAX : (n == 5) ? `RVLM_FREQ_MAX : (n == 6) ? 16'hFFFF : `RVLM_VAL_MAX;
    return (x > lim) ? lim : x;
  endfunction
  task automatic wb(input logic w, input logic [7:0] i, input logic [15:0] d, output logic [15:0] r,
                    output logic er);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'b00}; dat <= {16'h0000, d};
    do begin @(posedge clk_i); n++; end while (!(ack === 1'b1 || err === 1'b1) && n < 50);
    if (n >= 50) errors++;
    r = rdat[15:0];
    er = err;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    total_checks++;
    if (got !== ex) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #5 clk_i = ~clk_i;
  initial begin repeat (5000) @(posedge clk_i); errors++; report_and_stop; end
  initial begin
    for (k = 0; k < 16; k++) v[k] = 16'h0000;
    cfgs = '{16'h1F3D, 16'h5F2D, 16'h1F30, 16'h5F20, 16'h0080};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) begin
      for (k = 0; k < 16; k++) v[k] <= 16'($random(seed));
      for (k = 0; k < 16; k++) begin wb(1'b0, idx(k), 16'h0, q, e); chk("status", model_rd(k, v[k]), q); end
    end
    wb(1'b1, 8'h24, 16'h0001, q, e); wb(1'b0, 8'h24, 16'h0, q, e); chk("ro write", model_rd(4, v[4]), q);
    for (k = 0; k < 5; k++) begin
      cfg <= cfgs[k];
      repeat (3) @(posedge clk_i);
      wb(1'b0, 8'h27, 16'h0, q, e); chk("active cfg", cfgs[k], q);
      chk("window", cfgs[k][3] ? 16'h0020 : 16'h0040, {9'h000, win});
      chk("hz60", {15'h0, cfgs[k][14] & ~cfgs[k][4] & ~v[6][4]}, {15'h0, hz60});
      chk("remote", {15'h0, cfgs[k][7] & ~cfgs[k][12]}, {15'h0, remote});
      wb(1'b1, 8'h31, 16'h0ABC + 16'(k), q, e); @(posedge clk_i);
      chk("ref", cfgs[k][7] ? 16'h0ABC + 16'(k) : sref, aref);
    end
    wb(1'b1, 8'h28, 16'h5A3C, q, e); chk("cmd strobe", 16'h0001, {15'h0, cstb});
    chk("cmd word", 16'h5A3C, cmd);
    wb(1'b0, 8'h3F, 16'h0, q, e); chk("unmapped", 16'h0001, {15'h0, e});
    report_and_stop;
  end
endmodule // regulator_volatile_location_map_test
`default_nettype wire

// ===== rvlm_defs.vh
// Constants for the regulator volatile location map.
// Assumes a Wishbone slave with 32-bit data, one location per aligned word.
`ifndef RVLM_DEFS_VH
`define RVLM_DEFS_VH

// Location indices; byte address is four times the index.
`define RVLM_IDX_VOLT_KNOB    8'h20
`define RVLM_IDX_STABILITY_KNOB_KNOB    8'h21
`define RVLM_IDX_USPD_KNOB    8'h22
`define RVLM_IDX_EXC_KNOB     8'h23
`define RVLM_IDX_REG_VOLT     8'h24
`define RVLM_IDX_FREQ         8'h25
`define RVLM_IDX_ALARM        8'h26
`define RVLM_IDX_ACT_CFG      8'h27
`define RVLM_IDX_CMD          8'h28
`define RVLM_IDX_EXT_LVL      8'h29
`define RVLM_IDX_SETPT        8'h2A
`define RVLM_IDX_ADJ_SETPT    8'h2B
`define RVLM_IDX_MEAS_VOLT    8'h2C
`define RVLM_IDX_TEMP         8'h2D
`define RVLM_IDX_REMOTE_REF   8'h31
`define RVLM_IDX_KP           8'h35
`define RVLM_IDX_KI           8'h36
`define RVLM_IDX_OVEREXC      8'h37
`define RVLM_IDX_UNDEREXC     8'h38

// Active-configuration and alarm bit positions.
`define RVLM_CFG_RMS          0
`define RVLM_CFG_PERIODIC     1
`define RVLM_CFG_OFFSET       2
`define RVLM_CFG_WIN32        3
`define RVLM_CFG_JUMPER       4
`define RVLM_CFG_REMOTE_RAM   7
`define RVLM_CFG_VOLT_KNOB    8
`define RVLM_CFG_STABILITY_KNOB_KNOB    9
`define RVLM_CFG_USPD_KNOB    10
`define RVLM_CFG_EXC_KNOB     11
`define RVLM_CFG_EXT_IN       12
`define RVLM_CFG_EXT_DAC      13
`define RVLM_CFG_60HZ         14
`define RVLM_ALARM_JUMPER     4

// Range limits.
`define RVLM_VOLT_MAX         16'h0C80
`define RVLM_FREQ_MAX         16'h0384
`define RVLM_VAL_MAX          16'h7FFF

// Reset values.
`define RVLM_CFG_RESET        16'h1F3D
`define RVLM_REF_RESET        16'h0000

// Window lengths of the voltage measurement.
`define RVLM_WIN_SHORT        7'h20
`define RVLM_WIN_LONG         7'h40

`endif

// ===== rvlm_map.v
// Volatile location map of a digital generator voltage regulator.
// Assumes a classic Wishbone master with 32-bit data; regulator values arrive on same-clock ports.
// Function
// - Location 36 reads regulated voltage in tenths of a volt, up to 3200.
// - Location 37 reads generator frequency in tenths of a hertz, up to 900.
// - Location 41 reads remote input or external potentiometer level, 0 to 32767.
// - Location 43 reads altered working setpoint; location 42 reads unaltered setpoint.
// - Location 45 reads exciter winding temperature estimate, 0 to 32767.
// - Location 49 steers voltage only with external input off and bit 7 set.
// - Locations 53 and 54 read scaled proportional and integral gains.
// - Location 55 reads the overexcitation protection trip threshold.
// - Location 56 reads the underexcitation observer value.
// - Location 39 active configuration is refreshed every cycle.
// - Bit 0 means RMS regulation, bit 1 periodic reference variation.
// - Bit 2 means automatic offset compensation of voltage channels enabled.
// - Bit 3 selects a 32-sample voltage window, else 64 samples.
// - Bit 7 means remote RAM voltage control or input saturation on overflow.
// - Bits 8 to 11 enable reading of the four knobs, one each; the map reads all four knobs whatever these bits hold.
// - Bit 12 enables external voltage input, bit 13 external converter output.
// - Bit 14 selects 60 Hz only when alarm bit 4 and config bit 4 are zero.
// - Word reads 7997 or 24365 for RMS, 7984 or 24352 for averaging.
// - With bit 7 clear, reference tracks stored parameter and host writes are void.
// - Active configuration bits follow the configuration parameter bit for bit.

`timescale 1ns/10ps
`default_nettype none
`include "rvlm_defs.vh"

module rvlm_map (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // Regulator values.
  input  wire [15:0] volt_knob_i,
  input  wire [15:0] stability_knob_knob_i,
  input  wire [15:0] uspd_knob_i,
  input  wire [15:0] exc_knob_i,
  input  wire [15:0] reg_volt_i,
  input  wire [15:0] freq_i,
  input  wire [15:0] alarm_i,
  input  wire [15:0] ext_lvl_i,
  input  wire [15:0] setpt_i,
  input  wire [15:0] adj_setpt_i,
  input  wire [15:0] meas_volt_i,
  input  wire [15:0] temp_i,
  input  wire [15:0] kp_i,
  input  wire [15:0] ki_i,
  input  wire [15:0] overexc_i,
  input  wire [15:0] underexc_i,
  // Configuration parameter and stored reference.
  input  wire [15:0] cfg_param_i,
  input  wire [15:0] stored_ref_i,
  // Derived control.
  output reg  [15:0] active_ref_o,
  output reg         use_remote_ref_o,
  output reg         freq_60hz_o,
  output reg  [6:0]  volt_window_o,
  output reg  [15:0] command_o,
  output reg         command_stb_o
);

  reg  [15:0] act_cfg_r;
  reg  [15:0] remote_ref_r;
  reg  [15:0] rd_nxt;
  reg         hit_nxt;
  wire        req;
  wire        wr_ok;
  wire [7:0]  idx;

  // Clips a value to a documented ceiling.
  function [15:0] clip;
    input [15:0] v;
    input [15:0] lim;
    begin
      clip = (v > lim) ? lim : v;
    end
  endfunction

  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign idx   = wb_adr_i[9:2];
  // Only the low lanes carry the 16-bit locations, so both must be enabled to write.
  assign wr_ok = req & wb_we_i & hit_nxt & wb_sel_i[0] & wb_sel_i[1];

  // The configuration word is resampled every cycle so reads never lag by more than one.
  always @(posedge clk_i) begin
    if (rst_i) begin
      act_cfg_r <= `RVLM_CFG_RESET;
    end else begin
      act_cfg_r <= cfg_param_i;
    end
  end

  always @* begin
    hit_nxt = 1'b1;
    rd_nxt  = 16'h0000;
    case (idx)
      `RVLM_IDX_VOLT_KNOB:  rd_nxt = clip(volt_knob_i, `RVLM_VAL_MAX);
      `RVLM_IDX_STABILITY_KNOB_KNOB:  rd_nxt = clip(stability_knob_knob_i, `RVLM_VAL_MAX);
      `RVLM_IDX_USPD_KNOB:  rd_nxt = clip(uspd_knob_i, `RVLM_VAL_MAX);
      `RVLM_IDX_EXC_KNOB:   rd_nxt = clip(exc_knob_i, `RVLM_VAL_MAX);
      `RVLM_IDX_REG_VOLT:   rd_nxt = clip(reg_volt_i, `RVLM_VOLT_MAX);
      `RVLM_IDX_FREQ:       rd_nxt = clip(freq_i, `RVLM_FREQ_MAX);
      `RVLM_IDX_ALARM:      rd_nxt = alarm_i;
      `RVLM_IDX_ACT_CFG:    rd_nxt = act_cfg_r;
      `RVLM_IDX_CMD:        rd_nxt = 16'h0000;
      `RVLM_IDX_EXT_LVL:    rd_nxt = clip(ext_lvl_i, `RVLM_VAL_MAX);
      `RVLM_IDX_SETPT:      rd_nxt = clip(setpt_i, `RVLM_VAL_MAX);
      `RVLM_IDX_ADJ_SETPT:  rd_nxt = clip(adj_setpt_i, `RVLM_VAL_MAX);
      `RVLM_IDX_MEAS_VOLT:  rd_nxt = clip(meas_volt_i, `RVLM_VAL_MAX);
      `RVLM_IDX_TEMP:       rd_nxt = clip(temp_i, `RVLM_VAL_MAX);
      `RVLM_IDX_REMOTE_REF: rd_nxt = remote_ref_r;
      `RVLM_IDX_KP:         rd_nxt = clip(kp_i, `RVLM_VAL_MAX);
      `RVLM_IDX_KI:         rd_nxt = clip(ki_i, `RVLM_VAL_MAX);
      `RVLM_IDX_OVEREXC:    rd_nxt = clip(overexc_i, `RVLM_VAL_MAX);
      `RVLM_IDX_UNDEREXC:   rd_nxt = clip(underexc_i, `RVLM_VAL_MAX);
      default:              hit_nxt = 1'b0;
    endcase
  end

  // One-cycle answer; unmapped indices end with err instead of ack.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o      <= 1'b0;
      wb_err_o      <= 1'b0;
      wb_dat_o      <= 32'h00000000;
      command_o     <= 16'h0000;
      command_stb_o <= 1'b0;
    end else begin
      wb_ack_o      <= req & hit_nxt;
      wb_err_o      <= req & ~hit_nxt;
      command_stb_o <= 1'b0;
      if (req & ~wb_we_i & hit_nxt) begin
        wb_dat_o <= {16'h0000, rd_nxt};
      end
      // Writes land only in the command and reference words; the rest are ignored.
      if (wr_ok && idx == `RVLM_IDX_CMD) begin
        command_o     <= wb_dat_i[15:0];
        command_stb_o <= 1'b1;
      end
    end
  end

  // With bit 7 clear the reference mirrors the stored parameter and host writes are dropped.
  always @(posedge clk_i) begin
    if (rst_i) begin
      remote_ref_r <= `RVLM_REF_RESET;
    end else if (!act_cfg_r[`RVLM_CFG_REMOTE_RAM]) begin
      remote_ref_r <= clip(stored_ref_i, `RVLM_VAL_MAX);
    end else if (wr_ok && idx == `RVLM_IDX_REMOTE_REF) begin
      remote_ref_r <= clip(wb_dat_i[15:0], `RVLM_VAL_MAX);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      use_remote_ref_o <= 1'b0;
      active_ref_o     <= 16'h0000;
      freq_60hz_o      <= 1'b0;
      volt_window_o    <= `RVLM_WIN_LONG;
    end else begin
      use_remote_ref_o <= act_cfg_r[`RVLM_CFG_REMOTE_RAM] & ~act_cfg_r[`RVLM_CFG_EXT_IN];
      active_ref_o     <= remote_ref_r;
      freq_60hz_o      <= act_cfg_r[`RVLM_CFG_60HZ] & ~act_cfg_r[`RVLM_CFG_JUMPER]
                          & ~alarm_i[`RVLM_ALARM_JUMPER];
      volt_window_o    <= act_cfg_r[`RVLM_CFG_WIN32] ? `RVLM_WIN_SHORT : `RVLM_WIN_LONG;
    end
  end

  // Bits 8 to 11, 13 and 15 are passed through untouched; their consumers sit outside this map.

endmodule // rvlm_map

`default_nettype wire

// ===== rvlm_map_asserts.sv
// Checker for the regulator volatile location map.
// Assumes it is bound to rvlm_map and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "rvlm_defs.vh"
module rvlm_map_chk (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [15:0] reg_volt_i, alarm_i, cfg_param_i, stored_ref_i, active_ref_o,
  input wire logic        use_remote_ref_o, freq_60hz_o,
  input wire logic [6:0]  volt_window_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] up_r;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  // Past-two checks need two edges of real history after reset.
  always @(posedge clk_i) begin
    if (rst_i) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  chk_answer_next: assert property (take |=> (wb_ack_o ^ wb_err_o)) else $error("No single answer.");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("Ack held too long.");
  chk_volt_read: assert property (take && !wb_we_i && wb_adr_i[9:2] == 8'h24 |=> wb_dat_o[15:0] ==
    (($past(reg_volt_i) > `RVLM_VOLT_MAX) ? `RVLM_VOLT_MAX : $past(reg_volt_i))) else $error("Volt read.");
  chk_cfg_read: assert property (up_r == 2'h3 && take && !wb_we_i && wb_adr_i[9:2] == 8'h27 |=>
    wb_dat_o[15:0] == $past(cfg_param_i, 2)) else $error("Config read.");
  chk_window_sel: assert property (up_r == 2'h3 |-> volt_window_o ==
    ($past(cfg_param_i[3], 2) ? 7'h20 : 7'h40)) else $error("Window wrong.");
  chk_remote_sel: assert property (up_r == 2'h3 |-> use_remote_ref_o ==
    ($past(cfg_param_i[7], 2) && !$past(cfg_param_i[12], 2))) else $error("Remote select wrong.");
  chk_hz_sel: assert property (up_r == 2'h3 && $past(alarm_i[4]) == $past(alarm_i[4], 2) |-> freq_60hz_o ==
    ($past(cfg_param_i[14], 2) && !$past(cfg_param_i[4], 2) && !$past(alarm_i[4]))) else $error("60 Hz wrong.");
  chk_ref_track: assert property (up_r == 2'h3 && !$past(cfg_param_i[7], 3) |->
    active_ref_o == (($past(stored_ref_i, 2) > `RVLM_VAL_MAX) ? `RVLM_VAL_MAX : $past(stored_ref_i, 2)))
    else $error("Reference not tracking.");
endmodule // rvlm_map_chk
bind rvlm_map rvlm_map_chk rvlm_map_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .wb_err_o, .wb_adr_i, .wb_dat_o, .reg_volt_i, .alarm_i, .cfg_param_i, .stored_ref_i, .active_ref_o,
  .use_remote_ref_o, .freq_60hz_o, .volt_window_o);
`default_nettype wire
